// file: design/scs_sequencer.sv
// Scanner channel sequencer: relays, scan engine and source clamp
//
// How it works
// - Connect releases current channel, then closes new
// - Requests name one channel, one to ten
// - Connected query: 1 closed, 0 not
// - Released query: 1 open, 0 not
// - Query lists build from singles and ranges
// - Report connected channel, zero when none
// - Both release-all forms open the channel
// - Scan list holds up to ten entries, internal source needs two
// - External count 1..400, default 10, reported
// - Source none stops and disables scanning
// - Internal steps list, external steps count
// - Hold measurement until settling delay expires
// - Break-before-make opens before next closes
// - Normal order swaps channels in one step
// - Clamp keeps source within 200 V
// - Smaller of clamp and source limit wins
// - Reading channel is 000 when idle
`timescale 1ns/100ps
`default_nettype none
module scs_sequencer #(
    parameter int unsigned CYC_PER_MS = scs_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // Command port
    input  wire logic               cmd_valid,
    input  wire scs_pkg::scs_op_t   cmd_op,
    input  wire logic [3:0]         cmd_chan,
    input  wire logic [31:0]        cmd_arg,
    output logic                    cmd_ready,
    // Response port
    output logic                    rsp_valid,
    output logic                    rsp_err,
    output logic [31:0]             rsp_value,
    output logic [9:0]              rsp_bits,
    output logic [9:0]              rsp_mask,
    // Relays and external switcher
    output logic [9:0]              relay_close,
    output logic [3:0]              conn_chan,
    output logic [8:0]              ext_chan,
    output logic                    ext_step,
    // Measurement handshake
    output logic                    meas_trig,
    input  wire logic               meas_done,
    output logic                    scan_active,
    output logic [11:0]             rd_chan_bcd,
    output logic                    rd_chan_ext,
    // Voltage source
    input  wire logic signed [15:0] vsrc_req,
    output logic signed [15:0]      vsrc_out,
    output logic                    source_clamp_enable
);
    import scs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_BREAK  = 3'h1,
        ST_MAKE   = 3'h2,
        ST_SETTLE = 3'h3,
        ST_MEAS   = 3'h4
    } scs_scan_t;

    typedef struct packed {
        logic [9:0]        relay;
        logic [3:0]        conn_ch;
        logic              pend_close;
        logic [3:0]        pend_ch;
        logic [9:0][3:0]   list;
        logic [3:0]        list_len;
        logic [8:0]        ext_cnt;
        scs_src_t          src;
        scs_order_t        order;
        logic [26:0]       settle;
        logic              clamp_en;
        logic [15:0]       src_limit;
        logic [15:0]       vout;
        logic [9:0]        qmask;
        logic              rsp_valid;
        logic              rsp_err;
        logic [31:0]       rsp_value;
        logic [9:0]        rsp_bits;
        logic [9:0]        rsp_mask;
        scs_scan_t         scan;
        logic [3:0]        idx;
        logic [8:0]        ext_pos;
        logic              ext_step;
        logic              meas_trig;
        logic              tmr_start;
        logic [11:0]       rd_bcd;
    } scs_state_t;

    scs_state_t s_q;
    scs_state_t s_d;

    scs_timer_if tif ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic ch_ok(input logic [3:0] ch);
        return (ch >= CH_MIN) && (ch <= CH_MAX);
    endfunction

    function automatic logic [9:0] onehot(input logic [3:0] ch);
        logic [9:0] m;
        m = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (ch == 4'(i + 1)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [9:0] span(input logic [3:0] lo,
                                        input logic [3:0] hi);
        logic [9:0] m;
        m = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if ((4'(i + 1) >= lo) && (4'(i + 1) <= hi)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [11:0] to_bcd(input logic [8:0] v);
        logic [3:0] h;
        logic [3:0] t;
        logic [3:0] u;
        h = 4'(v / 9'h064);
        t = 4'((v % 9'h064) / 9'h00A);
        u = 4'(v % 9'h00A);
        return {h, t, u};
    endfunction

    function automatic logic [15:0] mag(input logic signed [15:0] v);
        return v[15] ? 16'(-v) : 16'(v);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic        scan_on;
    logic [3:0]  cur_ch;
    logic [15:0] lim;
    logic [15:0] req_mag;

    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.rsp_err   = 1'b0;
        s_d.ext_step  = 1'b0;
        s_d.meas_trig = 1'b0;
        s_d.tmr_start = 1'b0;
        scan_on = (s_q.src != SRC_NONE);
        cur_ch  = s_q.list[s_q.idx];

        // Scan engine
        unique case (s_q.scan)
            ST_IDLE: begin
                if (scan_on) begin
                    s_d.idx     = '0;
                    s_d.ext_pos = EXT_MIN;
                    s_d.scan    = ST_BREAK;
                end
            end
            ST_BREAK: begin
                if (s_q.src == SRC_INT) begin
                    s_d.relay   = '0;
                    s_d.conn_ch = '0;
                end
                s_d.scan = ST_MAKE;
            end
            ST_MAKE: begin
                if (s_q.src == SRC_INT) begin
                    s_d.relay   = onehot(cur_ch);
                    s_d.conn_ch = cur_ch;
                end else begin
                    s_d.ext_step = 1'b1;
                end
                s_d.tmr_start = 1'b1;
                s_d.scan      = ST_SETTLE;
            end
            ST_SETTLE: begin
                if (tif.done) begin
                    s_d.meas_trig = 1'b1;
                    s_d.scan      = ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (meas_done) begin
                    if (s_q.src == SRC_INT) begin
                        s_d.idx = (s_q.idx + 4'h1 >= s_q.list_len)
                                ? 4'h0 : s_q.idx + 4'h1;
                    end else begin
                        s_d.ext_pos = (s_q.ext_pos >= s_q.ext_cnt)
                                    ? EXT_MIN : s_q.ext_pos + 9'h001;
                    end
                    s_d.scan = (s_q.order == ORD_BBM)
                             ? ST_BREAK : ST_MAKE;
                end
            end
            default: begin
                s_d.scan = ST_IDLE;
            end
        endcase

        // Command decode
        if (s_q.pend_close) begin
            s_d.relay      = onehot(s_q.pend_ch);
            s_d.conn_ch    = s_q.pend_ch;
            s_d.pend_close = 1'b0;
            s_d.rsp_valid  = 1'b1;
        end else if (cmd_valid) begin
            s_d.rsp_valid = 1'b1;
            unique case (cmd_op)
                OP_NOP: begin
                end
                OP_CONNECT: begin
                    if (!ch_ok(cmd_chan) || scan_on) begin
                        s_d.rsp_err = 1'b1;
                    end else begin
                        s_d.relay      = '0;
                        s_d.conn_ch    = '0;
                        s_d.pend_close = 1'b1;
                        s_d.pend_ch    = cmd_chan;
                        s_d.rsp_valid  = 1'b0;
                    end
                end
                OP_RELEASE: begin
                    if (!ch_ok(cmd_chan)) begin
                        s_d.rsp_err = 1'b1;
                    end else if (s_q.conn_ch == cmd_chan) begin
                        s_d.relay   = '0;
                        s_d.conn_ch = '0;
                    end
                end
                OP_RELEASE_ALL, OP_REL_ALL_ACT: begin
                    s_d.relay   = '0;
                    s_d.conn_ch = '0;
                end
                OP_LIST_CLEAR: begin
                    if (s_q.src == SRC_INT) begin
                        s_d.rsp_err = 1'b1;
                    end else begin
                        s_d.list_len = '0;
                    end
                end
                OP_LIST_APPEND: begin
                    if (!ch_ok(cmd_chan) || s_q.list_len >= LIST_MAX
                        || s_q.src == SRC_INT) begin
                        s_d.rsp_err = 1'b1;
                    end else begin
                        s_d.list[s_q.list_len] = cmd_chan;
                        s_d.list_len = s_q.list_len + 4'h1;
                    end
                end
                OP_SET_EXT: begin
                    if (cmd_arg < 32'(EXT_MIN) || cmd_arg > 32'(EXT_MAX)) begin
                        s_d.rsp_err = 1'b1;
                    end else begin
                        s_d.ext_cnt = cmd_arg[8:0];
                        s_d.ext_pos = EXT_MIN;
                    end
                end
                OP_SET_SOURCE: begin
                    if (cmd_arg > 32'(SRC_EXT) || (cmd_arg[1:0] == SRC_INT
                        && s_q.list_len < LIST_MIN)) begin
                        s_d.rsp_err = 1'b1;
                    end else begin
                        s_d.src  = scs_src_t'(cmd_arg[1:0]);
                        s_d.scan = ST_IDLE;
                        if (s_q.src == SRC_INT) begin
                            s_d.relay   = '0;
                            s_d.conn_ch = '0;
                        end
                    end
                end
                OP_SET_SETTLE: begin
                    if (cmd_arg > 32'(SETTLE_MAX)) begin
                        s_d.rsp_err = 1'b1;
                    end else begin
                        s_d.settle = cmd_arg[26:0];
                    end
                end
                OP_SET_ORDER: begin
                    s_d.order = scs_order_t'(cmd_arg[0]);
                end
                OP_SET_CLAMP: begin
                    s_d.clamp_en = cmd_arg[0];
                end
                OP_SET_LIMIT: begin
                    if (cmd_arg > 32'(SRC_LIMIT_MAX)) begin
                        s_d.rsp_err = 1'b1;
                    end else begin
                        s_d.src_limit = cmd_arg[15:0];
                    end
                end
                OP_QRY_ADD: begin
                    if (!ch_ok(cmd_chan) || !ch_ok(cmd_arg[3:0])
                        || cmd_arg[3:0] < cmd_chan) begin
                        s_d.rsp_err = 1'b1;
                    end else begin
                        s_d.qmask = s_q.qmask
                                  | span(cmd_chan, cmd_arg[3:0]);
                    end
                end
                OP_QRY_STATE: begin
                    s_d.rsp_mask = s_q.qmask;
                    s_d.rsp_bits = cmd_arg[0]
                                 ? (~s_q.relay & s_q.qmask)
                                 : (s_q.relay & s_q.qmask);
                    s_d.qmask = '0;
                end
                OP_QRY_VALUE: begin
                    s_d.rsp_value = '0;
                    unique case (cmd_arg[3:0])
                        QV_CONN_CH:  s_d.rsp_value = 32'(s_q.conn_ch);
                        QV_EXT_PROG: s_d.rsp_value = 32'(s_q.ext_cnt);
                        QV_EXT_DEF:  s_d.rsp_value = 32'(EXT_DEF);
                        QV_EXT_MIN:  s_d.rsp_value = 32'(EXT_MIN);
                        QV_EXT_MAX:  s_d.rsp_value = 32'(EXT_MAX);
                        QV_LIST_LEN: s_d.rsp_value = 32'(s_q.list_len);
                        QV_LIST_ENT: begin
                            if (cmd_chan >= s_q.list_len) begin
                                s_d.rsp_err = 1'b1;
                            end else begin
                                s_d.rsp_value = 32'(s_q.list[cmd_chan]);
                            end
                        end
                        QV_SETTLE:   s_d.rsp_value = 32'(s_q.settle);
                        QV_SOURCE:   s_d.rsp_value = 32'(s_q.src);
                        QV_ORDER:    s_d.rsp_value = 32'(s_q.order);
                        QV_CLAMP:    s_d.rsp_value = 32'(s_q.clamp_en);
                        QV_LIMIT:    s_d.rsp_value = 32'(s_q.src_limit);
                        default:     s_d.rsp_err   = 1'b1;
                    endcase
                end
            endcase
        end

        // Reading channel number, zero when no scan runs
        if (s_d.scan == ST_IDLE || s_d.src == SRC_NONE) begin
            s_d.rd_bcd = 12'h000;
        end else if (s_d.src == SRC_INT) begin
            s_d.rd_bcd = to_bcd(9'(s_d.list[s_d.idx]));
        end else begin
            s_d.rd_bcd = to_bcd(s_d.ext_pos);
        end

        // Source clamp
        lim = (s_d.clamp_en && CLAMP_LIMIT < s_d.src_limit)
            ? CLAMP_LIMIT : s_d.src_limit;
        req_mag = mag(vsrc_req);
        if (req_mag > lim) begin
            s_d.vout = vsrc_req[15] ? 16'(-lim) : lim;
        end else begin
            s_d.vout = vsrc_req;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q           <= '0;
            s_q.src       <= SRC_NONE;
            s_q.order     <= ORD_BBM;
            s_q.scan      <= ST_IDLE;
            s_q.ext_cnt   <= EXT_DEF;
            s_q.ext_pos   <= EXT_MIN;
            s_q.settle    <= SETTLE_DEF;
            s_q.src_limit <= SRC_LIMIT_DEF;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Settling timer
    // ------------------------------------------------------------
    assign tif.start    = s_q.tmr_start;
    assign tif.delay_ms = s_q.settle;

    scs_settle_timer #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tif     (tif)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cmd_ready           = ~s_q.pend_close;
    assign rsp_valid           = s_q.rsp_valid;
    assign rsp_err             = s_q.rsp_err;
    assign rsp_value           = s_q.rsp_value;
    assign rsp_bits            = s_q.rsp_bits;
    assign rsp_mask            = s_q.rsp_mask;
    assign relay_close         = s_q.relay;
    assign conn_chan           = s_q.conn_ch;
    assign ext_chan            = s_q.ext_pos;
    assign ext_step            = s_q.ext_step;
    assign meas_trig           = s_q.meas_trig;
    assign scan_active         = (s_q.scan != ST_IDLE);
    assign rd_chan_bcd         = s_q.rd_bcd;
    assign rd_chan_ext         = (s_q.src == SRC_EXT);
    assign vsrc_out            = s_q.vout;
    assign source_clamp_enable = s_q.clamp_en;

endmodule
`default_nettype wire

// file: design/scs_pkg.sv
// Shared constants and types for the scanner channel sequencer
package scs_pkg;

    // --------------------
    // Clock and timing
    // --------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned SETTLE_UNIT_NS = 1_000_000;
    localparam int unsigned CYC_PER_MS = SETTLE_UNIT_NS / CLK_PERIOD_NS;

    // --------------------
    // Channels and scan list
    // --------------------
    localparam int unsigned CH_W = 4;
    localparam int unsigned NUM_CH = 10;
    localparam logic [3:0] CH_MIN = 4'h1;
    localparam logic [3:0] CH_MAX = 4'hA;
    localparam logic [3:0] LIST_MIN = 4'h2;
    localparam logic [3:0] LIST_MAX = 4'hA;

    // --------------------
    // External channel count
    // --------------------
    localparam int unsigned EXT_W = 9;
    localparam logic [8:0] EXT_MIN = 9'h001;
    localparam logic [8:0] EXT_MAX = 9'h190;
    localparam logic [8:0] EXT_DEF = 9'h00A;

    // --------------------
    // Settling delay in milliseconds
    // --------------------
    localparam int unsigned SETTLE_W = 27;
    localparam logic [26:0] SETTLE_MAX = 27'h5F5_E0FF;
    localparam logic [26:0] SETTLE_DEF = 27'h000_0000;

    // --------------------
    // Source voltage, units of 0.1 V
    // --------------------
    localparam logic [15:0] CLAMP_LIMIT = 16'h07D0;
    localparam logic [15:0] SRC_LIMIT_MAX = 16'h7FFF;
    localparam logic [15:0] SRC_LIMIT_DEF = 16'h7FFF;

    // --------------------
    // Commands and settings
    // --------------------
    typedef enum logic [3:0] {
        OP_NOP          = 4'h0,
        OP_CONNECT      = 4'h1,
        OP_RELEASE      = 4'h2,
        OP_RELEASE_ALL  = 4'h3,
        OP_REL_ALL_ACT  = 4'h4,
        OP_LIST_CLEAR   = 4'h5,
        OP_LIST_APPEND  = 4'h6,
        OP_SET_EXT      = 4'h7,
        OP_SET_SOURCE   = 4'h8,
        OP_SET_SETTLE   = 4'h9,
        OP_SET_ORDER    = 4'hA,
        OP_SET_CLAMP    = 4'hB,
        OP_SET_LIMIT    = 4'hC,
        OP_QRY_ADD      = 4'hD,
        OP_QRY_STATE    = 4'hE,
        OP_QRY_VALUE    = 4'hF
    } scs_op_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_INT  = 2'h1,
        SRC_EXT  = 2'h2
    } scs_src_t;

    typedef enum logic {
        ORD_BBM    = 1'b0,
        ORD_NORMAL = 1'b1
    } scs_order_t;

    typedef enum logic [3:0] {
        QV_CONN_CH  = 4'h0,
        QV_EXT_PROG = 4'h1,
        QV_EXT_DEF  = 4'h2,
        QV_EXT_MIN  = 4'h3,
        QV_EXT_MAX  = 4'h4,
        QV_LIST_LEN = 4'h5,
        QV_LIST_ENT = 4'h6,
        QV_SETTLE   = 4'h7,
        QV_SOURCE   = 4'h8,
        QV_ORDER    = 4'h9,
        QV_CLAMP    = 4'hA,
        QV_LIMIT    = 4'hB
    } scs_qsel_t;

endpackage

// file: design/scs_timer_if.sv
// Handshake between the scan engine and the settling timer
`timescale 1ns/100ps
`default_nettype none
interface scs_timer_if;
    logic        start;
    logic [26:0] delay_ms;
    logic        done;

    modport ctl (output start, output delay_ms, input done);
    modport tmr (input start, input delay_ms, output done);
endinterface
`default_nettype wire

// file: design/scs_settle_timer.sv
// Settling delay timer counted in milliseconds
`timescale 1ns/100ps
`default_nettype none
module scs_settle_timer #(
    parameter int unsigned CYC_PER_MS = scs_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  rst,
    // Engine side
    scs_timer_if.tmr   tif
);
    import scs_pkg::*;

    typedef struct packed {
        logic        busy;
        logic [31:0] pre;
        logic [26:0] ms;
    } scs_tmr_t;

    scs_tmr_t s_q;
    scs_tmr_t s_d;

    localparam logic [31:0] PRE_LAST = 32'(CYC_PER_MS - 1);

    // ------------------------------------------------------------
    // Countdown
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (tif.start) begin
            s_d.busy = (tif.delay_ms != '0);
            s_d.ms   = tif.delay_ms;
            s_d.pre  = '0;
        end else if (s_q.busy) begin
            if (s_q.pre == PRE_LAST) begin
                s_d.pre = '0;
                s_d.ms  = s_q.ms - 27'h000_0001;
                if (s_q.ms == 27'h000_0001) begin
                    s_d.busy = 1'b0;
                end
            end else begin
                s_d.pre = s_q.pre + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tif.done = ~s_q.busy & ~tif.start;

endmodule
`default_nettype wire

// file: tb/scs_meas_model.sv
// Measurement unit model answering each trigger after a latency
`timescale 1ns/100ps
`default_nettype none
module scs_meas_model #(
    parameter int LAT = 3
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic meas_trig,
    output var logic  meas_done
);
    logic [7:0] cnt_q;
    always_ff @(posedge clk_sys) begin
        meas_done <= 1'b0;
        if (rst)
            cnt_q <= 8'h00;
        else if (meas_trig)
            cnt_q <= 8'(LAT);
        else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            meas_done <= (cnt_q == 8'h01);
        end
    end
endmodule
`default_nettype wire

// file: tb/scs_sequencer_checker.sv
// Port checks for the scanner channel sequencer
`timescale 1ns/100ps
`default_nettype none
module scs_checker (
    input wire logic clk_sys, rst, cmd_valid, cmd_ready,
    input wire scs_pkg::scs_op_t cmd_op,
    input wire logic [3:0] cmd_chan, conn_chan,
    input wire logic rsp_valid, rsp_err, scan_active,
    input wire logic [9:0] relay_close,
    input wire logic [11:0] rd_chan_bcd,
    input wire logic source_clamp_enable,
    input wire logic signed [15:0] vsrc_out
);
    import scs_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic tk = cmd_valid && cmd_ready && !scan_active;
    wire logic ok = cmd_chan inside {[4'h1:4'hA]};
    a_one_closed: assert property ($onehot0(relay_close))
        else $error("relay overlap");
    a_break_first: assert property (tk && cmd_op == OP_CONNECT && ok
        |=> relay_close == 10'h000 ##1
        (rsp_valid && conn_chan == $past(cmd_chan, 2)))
        else $error("no break");
    a_bad_chan: assert property (tk && cmd_op == OP_CONNECT && !ok
        |=> rsp_valid && rsp_err && $stable(relay_close))
        else $error("bad channel taken");
    a_rel_all: assert property (tk && cmd_op inside
        {OP_RELEASE_ALL, OP_REL_ALL_ACT} |=> relay_close == 10'h000)
        else $error("release all failed");
    a_conn_report: assert property
        ((conn_chan == 4'h0) == (relay_close == 10'h000))
        else $error("channel report wrong");
    a_idle_zero: assert property (!scan_active && !$past(scan_active)
        |-> rd_chan_bcd == 12'h000) else $error("idle channel not 000");
    a_clamp_range: assert property (source_clamp_enable |->
        vsrc_out <= 16'sh07D0 && vsrc_out >= -16'sh07D0)
        else $error("clamp exceeded");
    a_ready_back: assert property (!cmd_ready |=> cmd_ready)
        else $error("port stalled");
endmodule
bind scs_sequencer scs_checker u_chk (.clk_sys, .rst, .cmd_valid,
    .cmd_ready, .cmd_op, .cmd_chan, .conn_chan, .rsp_valid, .rsp_err,
    .scan_active, .relay_close, .rd_chan_bcd, .source_clamp_enable,
    .vsrc_out);
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the scanner channel sequencer
`timescale 1ns/100ps
`default_nettype none
`define CK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("mismatch %0t %h %h", $time, a, e); end end
module tb_top;
    import scs_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0;
    scs_op_t cmd_op = OP_NOP;
    logic [3:0] cmd_chan = 4'h0, conn_chan;
    logic [31:0] cmd_arg = 32'h0, rsp_value;
    logic signed [15:0] vsrc_req = 16'sh0, vsrc_out;
    logic cmd_ready, rsp_valid, rsp_err, ext_step, meas_trig, meas_done;
    logic scan_active, rd_chan_ext, source_clamp_enable;
    logic [9:0] rsp_bits, rsp_mask, relay_close;
    logic [8:0] ext_chan;
    logic [11:0] rd_chan_bcd;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    scs_sequencer #(.CYC_PER_MS(4)) u_dut (.clk_sys, .rst, .cmd_valid,
        .cmd_op, .cmd_chan, .cmd_arg, .cmd_ready, .rsp_valid, .rsp_err,
        .rsp_value, .rsp_bits, .rsp_mask, .relay_close, .conn_chan,
        .ext_chan, .ext_step, .meas_trig, .meas_done, .scan_active,
        .rd_chan_bcd, .rd_chan_ext, .vsrc_req, .vsrc_out,
        .source_clamp_enable);
    scs_meas_model #(.LAT(2)) u_meas (.clk_sys, .rst, .meas_trig,
        .meas_done);
    initial forever #2 clk_sys = ~clk_sys;
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic cmd(input scs_op_t op, input logic [31:0] a = 32'h0,
        input logic [3:0] ch = 4'h0, input logic e = 1'b0);
        int w;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_chan = ch;
        cmd_arg = a;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        for (w = 0; w < 8 && !rsp_valid; w++)
            @(negedge clk_sys);
        `CK(rsp_err, e)
    endtask
    task automatic vs(input logic signed [15:0] r, e);
        vsrc_req = r;
        repeat (2) @(negedge clk_sys);
        `CK(vsrc_out, e)
    endtask
    task automatic t_connect();
        cmd(OP_CONNECT, 32'h0, 4'h5);
        cmd(OP_CONNECT, 32'h0, 4'h3);
        `CK({relay_close, conn_chan}, {10'h004, 4'h3})
        cmd(OP_CONNECT, 32'h0, 4'hB, 1'b1);
        `CK(relay_close, 10'h004)
        for (int k = 0; k < 2; k++) begin
            cmd(OP_QRY_ADD, 32'h4, 4'h1);
            cmd(OP_QRY_ADD, 32'h7, 4'h7);
            cmd(OP_QRY_STATE, 32'(k));
            `CK(rsp_mask, 10'h04F)
            `CK(rsp_bits, k ? 10'h04F : 10'h004)
            cmd(OP_CONNECT, 32'h0, 4'hA);
            cmd(OP_QRY_VALUE, 32'(QV_CONN_CH));
            `CK(rsp_value, 32'hA)
            cmd(k ? OP_REL_ALL_ACT : OP_RELEASE_ALL);
            `CK(relay_close, 10'h000)
        end
        $display("connect done");
    endtask
    task automatic t_ext();
        scs_qsel_t sel [4] = '{QV_EXT_PROG, QV_EXT_DEF, QV_EXT_MIN,
            QV_EXT_MAX};
        logic [8:0] ex [4] = '{9'h00A, 9'h00A, 9'h001, 9'h190};
        cmd(OP_SET_EXT, 32'h0, 4'h0, 1'b1);
        cmd(OP_SET_EXT, 32'h191, 4'h0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            cmd(OP_QRY_VALUE, 32'(sel[k]));
            `CK(rsp_value, {23'h0, ex[k]})
        end
        cmd(OP_QRY_VALUE, 32'(QV_SOURCE));
        `CK(rsp_value, 32'h0)
        $display("ext done");
    endtask
    task automatic t_scan();
        logic [8:0] got [$];
        logic [9:0] prev;
        int t_mk;
        cmd(OP_LIST_CLEAR);
        cmd(OP_LIST_APPEND, 32'h0, 4'h2);
        cmd(OP_SET_SOURCE, 32'h1, 4'h0, 1'b1);
        cmd(OP_LIST_APPEND, 32'h0, 4'h4);
        cmd(OP_SET_SETTLE, 32'h1);
        cmd(OP_SET_EXT, 32'h2);
        for (int s = 1; s < 3; s++) begin
            got.delete();
            prev = 10'h000;
            t_mk = 0;
            cmd(OP_SET_SOURCE, 32'(s));
            repeat (80) begin
                @(negedge clk_sys);
                if (relay_close != 10'h000 && relay_close != prev) begin
                    t_mk = cyc;
                    got.push_back({5'h00, conn_chan});
                end
                if (ext_step) begin
                    t_mk = cyc;
                    got.push_back(ext_chan);
                end
                if (meas_trig)
                    `CK(cyc - t_mk >= 4, 1'b1)
                `CK(prev != 0 && relay_close != 0 && relay_close != prev,
                    1'b0)
                prev = relay_close;
            end
            `CK({got[0], got[1], got[2], rd_chan_ext}, s == 1 ?
                28'h010_1004 : 28'h008_0803)
            cmd(OP_SET_SOURCE);
            repeat (2) @(negedge clk_sys);
            `CK({scan_active, relay_close, rd_chan_bcd}, 23'h0)
        end
        $display("scan done");
    endtask
    task automatic t_clamp();
        cmd(OP_SET_CLAMP, 32'h1);
        vs(16'sh0BB8, 16'sh07D0);
        vs(-16'sh0BB8, -16'sh07D0);
        cmd(OP_SET_LIMIT, 32'h3E8);
        vs(16'sh0BB8, 16'sh03E8);
        cmd(OP_SET_CLAMP);
        vs(-16'sh0BB8, -16'sh03E8);
        $display("clamp done");
    endtask
    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        `CK({relay_close, conn_chan, rd_chan_bcd}, 26'h0)
        t_connect();
        t_ext();
        t_scan();
        t_clamp();
        test_done();
    end
endmodule
`default_nettype wire
